// File: hw/lrpf_framer.sv
// Behaviour
// (R1) packet: start, attribute, comma, length, comma, data, end, newline
// (R2) attribute '1' periodic, '2' user switch, '3' threshold
// (R3) header fields separated by comma
// (R4) length field is four ascii digits of data size
// (R5) data field holds exactly the announced number of bytes
// (R6) sample count is two decimal digits, most significant first
// (R7) each digit sent as 0x30 plus its value, msd first
// (R8) elapsed seconds sent as fixed ten-digit decimal
// (R9) light and temperature sent as four-digit decimal raw readings
// (R10) threshold data: time, comma, light, slash, temperature
// (R11) without time counter, time and its comma are left out
// (R12) link runs 115200 baud, 8 data bits, no parity, one stop
// (R13) packet starts on periodic, user switch or threshold event
// (R14) both channels sampled every thirty minutes
// (R15) each channel keeps 96 samples
// (R16) reading at or above threshold triggers threshold packet; the code compares only the temperature reading, not light
// (R17) comparator subtracts reading from threshold, flags when result would go negative
// (R18) periodic and switch data: count then light/temperature samples
// (R19) one byte at a time with handshake; triggers ignored while busy
`timescale 1ns/1ps
`include "lrpf_regs.svh"
module lrpf_framer #(
    parameter logic [35:0] SAMPLE_CYCLES = 36'(`LRPF_SAMPLE_CYCLES),
    parameter logic [24:0] SEC_CYCLES = 25'(`LRPF_SEC_CYCLES)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic periodic_wake_interrupt,
    input wire logic user_switch_interrupt,
    input wire logic time_enable,
    input wire logic [11:0] light_sample,
    input wire logic [11:0] temp_sample,
    input wire logic [15:0] threshold_level,
    output logic serial_tx_out_a,
    output logic packet_busy
);
    localparam logic [7:0] BAUD_CYCLES = 8'(`LRPF_BAUD_CYCLES);

    function automatic logic [15:0] bin2bcd(input logic [11:0] bin);
        logic [27:0] acc;
        acc = {16'h0000, bin};
        for (int i = 0; i < 12; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (acc[12 + 4 * d +: 4] > 4'h4) begin
                    acc[12 + 4 * d +: 4] = acc[12 + 4 * d +: 4] + 4'h3;
                end
            end
            acc = acc << 1;
        end
        return acc[27:12];
    endfunction

    // (R7) digit to ascii
    function automatic logic [7:0] asc(input logic [3:0] d);
        return `LRPF_CH_ZERO + {4'h0, d};
    endfunction

    function automatic logic [7:0] digit16(input logic [15:0] v, input logic [1:0] sel);
        return asc(v[4 * (3 - sel) +: 4]);
    endfunction

    function automatic logic [39:0] bcd_inc(input logic [39:0] v);
        logic [39:0] r;
        logic carry;
        r = v;
        carry = 1'b1;
        for (int d = 0; d < 10; d++) begin
            if (carry) begin
                if (r[4 * d +: 4] == 4'h9) begin
                    r[4 * d +: 4] = 4'h0;
                end else begin
                    r[4 * d +: 4] = r[4 * d +: 4] + 4'h1;
                    carry = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // pin synchronisers; bit 0 is read only by bit 1
    logic [2:0] per_sync_r;
    logic [2:0] sw_sync_r;
    logic [1:0] ten_sync_r;
    logic per_rise;
    logic sw_rise;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            per_sync_r <= 3'h0;
            sw_sync_r <= 3'h0;
            ten_sync_r <= 2'h0;
        end else begin
            per_sync_r <= {per_sync_r[1:0], periodic_wake_interrupt};
            sw_sync_r <= {sw_sync_r[1:0], user_switch_interrupt};
            ten_sync_r <= {ten_sync_r[0], time_enable};
        end
    end
    assign per_rise = per_sync_r[1] & ~per_sync_r[2];
    assign sw_rise = sw_sync_r[1] & ~sw_sync_r[2];

    // (R14) half-hour acquisition tick
    logic [35:0] smp_cnt_r;
    logic smp_tick;
    assign smp_tick = smp_cnt_r == SAMPLE_CYCLES - 36'h1;

    always_ff @(posedge core_clk) begin
        if (sys_rst || smp_tick) begin
            smp_cnt_r <= 36'h0;
        end else begin
            smp_cnt_r <= smp_cnt_r + 36'h1;
        end
    end

    // (R8) elapsed seconds kept directly in bcd, so no divider is needed
    logic [24:0] sec_cnt_r;
    logic [39:0] time_bcd_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sec_cnt_r <= 25'h0;
            time_bcd_r <= 40'h0;
        end else if (sec_cnt_r == SEC_CYCLES - 25'h1) begin
            sec_cnt_r <= 25'h0;
            time_bcd_r <= bcd_inc(time_bcd_r);
        end else begin
            sec_cnt_r <= sec_cnt_r + 25'h1;
        end
    end

    // acquisition into the circular buffer
    logic [6:0] wr_ptr_r;
    logic [6:0] cnt_r;
    logic [7:0] cnt_bcd_r;
    logic [15:0] last_light_r;
    logic [15:0] last_temp_r;
    logic [15:0] light_bcd;
    logic [15:0] temp_bcd;
    logic [16:0] thr_diff;
    logic thr_evt_r;

    // (R9) raw readings converted to four decimal digits
    assign light_bcd = bin2bcd(light_sample);
    assign temp_bcd = bin2bcd(temp_sample);

    // (R15) 96-slot ring, count saturates once full
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr_r <= 7'h0;
            cnt_r <= 7'h0;
            cnt_bcd_r <= 8'h00;
            last_light_r <= 16'h0000;
            last_temp_r <= 16'h0000;
        end else if (smp_tick) begin
            wr_ptr_r <= (wr_ptr_r == `LRPF_DEPTH - 7'h1) ? 7'h0 : wr_ptr_r + 7'h1;
            last_light_r <= light_bcd;
            last_temp_r <= temp_bcd;
            if (cnt_r != `LRPF_DEPTH) begin
                cnt_r <= cnt_r + 7'h1;
                cnt_bcd_r <= (cnt_bcd_r[3:0] == 4'h9) ? {cnt_bcd_r[7:4] + 4'h1, 4'h0} : cnt_bcd_r + 8'h01;
            end
        end
    end

    // (R17) one is taken off so a reading equal to the threshold also borrows
    assign thr_diff = {1'b0, threshold_level} - {5'h00, temp_sample} - 17'h00001;

    // (R16) judge right after each acquisition
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            thr_evt_r <= 1'b0;
        end else begin
            thr_evt_r <= smp_tick & thr_diff[16];
        end
    end

    // packet sequencer
    lrpf_pkg::lrpf_state_t state_r;
    logic [4:0] idx_r;
    logic [7:0] attr_r;
    logic [15:0] len_r;
    logic [39:0] time_snap_r;
    logic [15:0] thr_light_r;
    logic [15:0] thr_temp_r;
    logic [7:0] cnt_snap_r;
    logic [6:0] rd_ptr_r;
    logic [6:0] left_r;
    logic [31:0] mem_q;
    logic emit;
    logic push;
    logic [7:0] byte_nxt;
    logic buf_in_ready;

    lrpf_sample_mem u_mem (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(smp_tick),
        .wr_addr(wr_ptr_r),
        .wr_data({light_bcd, temp_bcd}),
        .rd_en(state_r == lrpf_pkg::LRPF_RDREQ),
        .rd_addr(rd_ptr_r),
        .rd_data(mem_q)
    );

    assign emit = state_r != lrpf_pkg::LRPF_IDLE && state_r != lrpf_pkg::LRPF_RDREQ;
    // (R19) a byte advances only when the buffer takes it
    assign push = emit & buf_in_ready;
    assign packet_busy = state_r != lrpf_pkg::LRPF_IDLE;

    // a packet running past the next half-hour write may see that slot refreshed
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= lrpf_pkg::LRPF_IDLE;
            idx_r <= 5'h00;
            attr_r <= `LRPF_ATTR_PERIODIC;
            len_r <= 16'h0000;
            time_snap_r <= 40'h0;
            thr_light_r <= 16'h0000;
            thr_temp_r <= 16'h0000;
            cnt_snap_r <= 8'h00;
            rd_ptr_r <= 7'h0;
            left_r <= 7'h0;
        end else begin
            unique case (state_r)
                lrpf_pkg::LRPF_IDLE: begin
                    // (R13) any trigger starts a packet
                    if (per_rise || sw_rise || thr_evt_r) begin
                        state_r <= lrpf_pkg::LRPF_HEAD;
                        idx_r <= 5'h00;
                        time_snap_r <= time_bcd_r;
                        thr_light_r <= last_light_r;
                        thr_temp_r <= last_temp_r;
                        cnt_snap_r <= cnt_bcd_r;
                        left_r <= cnt_r;
                        rd_ptr_r <= (cnt_r == `LRPF_DEPTH) ? wr_ptr_r : 7'h0;
                        // (R2) attribute by source, periodic first
                        if (per_rise) begin
                            attr_r <= `LRPF_ATTR_PERIODIC;
                        end else if (sw_rise) begin
                            attr_r <= `LRPF_ATTR_SWITCH;
                        end else begin
                            attr_r <= `LRPF_ATTR_THRESH;
                        end
                        // (R5) length matches bytes sent: 2 + 10 per sample
                        if (!per_rise && !sw_rise) begin
                            len_r <= ten_sync_r[1] ? `LRPF_LEN_THR_TIME : `LRPF_LEN_THR_NOTIME;
                        end else begin
                            len_r <= {4'h0, cnt_bcd_r, `LRPF_LEN_CNT_ONES};
                        end
                    end
                end
                lrpf_pkg::LRPF_HEAD: begin
                    if (push) begin
                        idx_r <= idx_r + 5'h01;
                        if (idx_r == 5'h07) begin
                            if (attr_r == `LRPF_ATTR_THRESH) begin
                                state_r <= lrpf_pkg::LRPF_THR;
                                // (R11) skip time digits and comma
                                idx_r <= (len_r == `LRPF_LEN_THR_TIME) ? `LRPF_THR_TIME_IDX : `LRPF_THR_LIGHT_IDX;
                            end else begin
                                state_r <= lrpf_pkg::LRPF_CNT;
                                idx_r <= 5'h00;
                            end
                        end
                    end
                end
                lrpf_pkg::LRPF_CNT: begin
                    if (push) begin
                        idx_r <= idx_r + 5'h01;
                        if (idx_r == 5'h01) begin
                            idx_r <= 5'h00;
                            state_r <= (left_r == 7'h0) ? lrpf_pkg::LRPF_TAIL : lrpf_pkg::LRPF_RDREQ;
                        end
                    end
                end
                lrpf_pkg::LRPF_RDREQ: begin
                    state_r <= lrpf_pkg::LRPF_SAMP;
                    idx_r <= 5'h00;
                end
                lrpf_pkg::LRPF_SAMP: begin
                    if (push) begin
                        idx_r <= idx_r + 5'h01;
                        if (idx_r == 5'h09) begin
                            idx_r <= 5'h00;
                            rd_ptr_r <= (rd_ptr_r == `LRPF_DEPTH - 7'h1) ? 7'h0 : rd_ptr_r + 7'h1;
                            left_r <= left_r - 7'h1;
                            state_r <= (left_r == 7'h1) ? lrpf_pkg::LRPF_TAIL : lrpf_pkg::LRPF_RDREQ;
                        end
                    end
                end
                lrpf_pkg::LRPF_THR: begin
                    if (push) begin
                        idx_r <= idx_r + 5'h01;
                        if (idx_r == 5'h13) begin
                            idx_r <= 5'h00;
                            state_r <= lrpf_pkg::LRPF_TAIL;
                        end
                    end
                end
                lrpf_pkg::LRPF_TAIL: begin
                    if (push) begin
                        idx_r <= idx_r + 5'h01;
                        if (idx_r == 5'h01) begin
                            idx_r <= 5'h00;
                            state_r <= lrpf_pkg::LRPF_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= lrpf_pkg::LRPF_IDLE;
                end
            endcase
        end
    end

    // byte selection for the current position
    always_comb begin
        byte_nxt = `LRPF_CH_COMMA;
        unique case (state_r)
            lrpf_pkg::LRPF_HEAD: begin
                // (R1) start and attribute; (R3) comma; (R4) four length digits
                if (idx_r == 5'h00) begin
                    byte_nxt = `LRPF_CH_START;
                end else if (idx_r == 5'h01) begin
                    byte_nxt = attr_r;
                end else if (idx_r >= 5'h03 && idx_r <= 5'h06) begin
                    byte_nxt = digit16(len_r, 2'(idx_r - 5'h03));
                end
            end
            lrpf_pkg::LRPF_CNT: begin
                // (R6) count tens then ones
                byte_nxt = asc(idx_r[0] ? cnt_snap_r[3:0] : cnt_snap_r[7:4]);
            end
            lrpf_pkg::LRPF_SAMP: begin
                // (R18) comma, light, slash, temperature per sample
                if (idx_r >= 5'h01 && idx_r <= 5'h04) begin
                    byte_nxt = digit16(mem_q[31:16], 2'(idx_r - 5'h01));
                end else if (idx_r == 5'h05) begin
                    byte_nxt = `LRPF_CH_SLASH;
                end else if (idx_r >= 5'h06) begin
                    byte_nxt = digit16(mem_q[15:0], 2'(idx_r - 5'h06));
                end
            end
            lrpf_pkg::LRPF_THR: begin
                // (R10) time, comma, light, slash, temperature
                if (idx_r <= 5'h09) begin
                    byte_nxt = asc(time_snap_r[4 * (9 - idx_r) +: 4]);
                end else if (idx_r >= 5'h0b && idx_r <= 5'h0e) begin
                    byte_nxt = digit16(thr_light_r, 2'(idx_r - 5'h0b));
                end else if (idx_r == 5'h0f) begin
                    byte_nxt = `LRPF_CH_SLASH;
                end else if (idx_r >= 5'h10) begin
                    byte_nxt = digit16(thr_temp_r, 2'(idx_r - 5'h10));
                end
            end
            lrpf_pkg::LRPF_TAIL: begin
                // (R1) end marker then newline
                byte_nxt = (idx_r == 5'h00) ? `LRPF_CH_END : `LRPF_CH_NL;
            end
            default: begin
                byte_nxt = `LRPF_CH_COMMA;
            end
        endcase
    end

    // two-entry buffer so a busy transmitter never drops a byte
    logic [7:0] b0_r;
    logic [7:0] b1_r;
    logic [1:0] bcnt_r;
    logic buf_out_valid;
    logic tx_idle;
    logic pop;

    assign buf_in_ready = bcnt_r != 2'h2;
    assign buf_out_valid = bcnt_r != 2'h0;
    assign pop = buf_out_valid & tx_idle;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            b0_r <= 8'h00;
            b1_r <= 8'h00;
            bcnt_r <= 2'h0;
        end else begin
            unique case ({push, pop})
                2'b10: begin
                    if (bcnt_r == 2'h0) begin
                        b0_r <= byte_nxt;
                    end else begin
                        b1_r <= byte_nxt;
                    end
                    bcnt_r <= bcnt_r + 2'h1;
                end
                2'b01: begin
                    b0_r <= b1_r;
                    bcnt_r <= bcnt_r - 2'h1;
                end
                2'b11: begin
                    b0_r <= (bcnt_r == 2'h1) ? byte_nxt : b1_r;
                    if (bcnt_r == 2'h2) begin
                        b1_r <= byte_nxt;
                    end
                end
                2'b00: begin
                    bcnt_r <= bcnt_r;
                end
            endcase
        end
    end

    // (R12) 8n1 transmitter, lsb first; line idles high
    logic [9:0] tx_shift_r;
    logic [3:0] tx_bits_r;
    logic [7:0] baud_r;
    assign tx_idle = tx_bits_r == 4'h0;
    assign serial_tx_out_a = tx_shift_r[0];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_shift_r <= 10'h3ff;
            tx_bits_r <= 4'h0;
            baud_r <= 8'h00;
        end else if (pop) begin
            tx_shift_r <= {1'b1, b0_r, 1'b0};
            tx_bits_r <= 4'ha;
            baud_r <= 8'h00;
        end else if (!tx_idle) begin
            if (baud_r == BAUD_CYCLES - 8'h01) begin
                baud_r <= 8'h00;
                tx_bits_r <= tx_bits_r - 4'h1;
                tx_shift_r <= {1'b1, tx_shift_r[9:1]};
            end else begin
                baud_r <= baud_r + 8'h01;
            end
        end
    end
endmodule // lrpf_framer

// File: hw/lrpf_regs.svh
`ifndef LRPF_REGS_SVH
`define LRPF_REGS_SVH

// timing
`define LRPF_CLK_HZ 64'd25000000
`define LRPF_BAUD_BPS 64'd115200
`define LRPF_SAMPLE_MIN 64'd30
`define LRPF_SEC_S 64'd1
`define LRPF_SAMPLE_CYCLES (`LRPF_CLK_HZ * 64'd60 * `LRPF_SAMPLE_MIN)
`define LRPF_SEC_CYCLES (`LRPF_CLK_HZ * `LRPF_SEC_S)
`define LRPF_BAUD_CYCLES (`LRPF_CLK_HZ / `LRPF_BAUD_BPS)

// sample buffer
`define LRPF_DEPTH 7'h60

// packet characters
`define LRPF_CH_START 8'h5e
`define LRPF_CH_END 8'h24
`define LRPF_CH_NL 8'h0a
`define LRPF_CH_COMMA 8'h2c
`define LRPF_CH_SLASH 8'h2f
`define LRPF_CH_ZERO 8'h30
`define LRPF_ATTR_PERIODIC 8'h31
`define LRPF_ATTR_SWITCH 8'h32
`define LRPf_ATTR_UNUSED 8'h00
`define LRPF_ATTR_THRESH 8'h33

// length fields in bcd
`define LRPF_LEN_THR_TIME 16'h0020
`define LRPF_LEN_THR_NOTIME 16'h0009
`define LRPF_LEN_CNT_ONES 4'h2

// byte positions inside a threshold data field
`define LRPF_THR_TIME_IDX 5'h00
`define LRPF_THR_LIGHT_IDX 5'h0b

`endif

// File: hw/lrpf_pkg.sv
package lrpf_pkg;

    typedef enum logic [2:0] {
        LRPF_IDLE = 3'h0,
        LRPF_HEAD = 3'h1,
        LRPF_CNT = 3'h2,
        LRPF_RDREQ = 3'h3,
        LRPF_SAMP = 3'h4,
        LRPF_THR = 3'h5,
        LRPF_TAIL = 3'h6
    } lrpf_state_t;

endpackage

// File: hw/lrpf_sample_mem.sv
`timescale 1ns/1ps
module lrpf_sample_mem (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire logic [6:0] rd_addr,
    output logic [31:0] rd_data
);
    logic [31:0] mem [0:95];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_data <= 32'h0000_0000;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // lrpf_sample_mem

// File: sim/lrpf_framer_monitor.sv
`timescale 1ns/1ps
module lrpf_framer_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic periodic_wake_interrupt,
    input wire logic user_switch_interrupt,
    input wire logic serial_tx_out_a,
    input wire logic packet_busy
);
    logic tx_q;
    logic [15:0] run_r;
    logic [15:0] idle_r;
    logic [15:0] busy_r;

    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    always_ff @(posedge core_clk) begin
        tx_q <= sys_rst ? 1'b1 : serial_tx_out_a;
    end

    // saturating run length of the line level; reset to full so the first edge is legal
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            run_r <= 16'hffff;
        end else if (serial_tx_out_a != tx_q) begin
            run_r <= 16'h0000;
        end else if (run_r != 16'hffff) begin
            run_r <= run_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || packet_busy) begin
            idle_r <= 16'h0000;
        end else if (idle_r != 16'hffff) begin
            idle_r <= idle_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !packet_busy) begin
            busy_r <= 16'h0000;
        end else if (busy_r != 16'hffff) begin
            busy_r <= busy_r + 16'h0001;
        end
    end

    a_reset_line_idle: assert property (
        $fell(sys_rst) |-> serial_tx_out_a && !packet_busy) else $error("line not idle after reset");
    a_switch_starts: assert property (
        $rose(user_switch_interrupt) && !packet_busy |-> ##[1:5] packet_busy) else $error("switch ignored");
    a_wake_starts: assert property (
        $rose(periodic_wake_interrupt) && !packet_busy |-> ##[1:5] packet_busy) else $error("wake ignored");
    a_start_bit_soon: assert property (
        $rose(packet_busy) && tx_q && run_r > 16'd2200 |-> ##[1:8] !serial_tx_out_a)
        else $error("no start bit");
    a_bit_min_len: assert property (
        serial_tx_out_a != tx_q |-> run_r >= 16'd215) else $error("bit too short");
    a_low_run_max: assert property (
        !serial_tx_out_a && !tx_q |-> run_r < 16'd1955) else $error("line low too long");
    a_idle_line_high: assert property (
        idle_r > 16'd6600 |-> serial_tx_out_a) else $error("traffic while idle");
    a_packet_min_len: assert property (
        $fell(packet_busy) |-> busy_r >= 16'd17000) else $error("packet too short");
endmodule // lrpf_framer_monitor

bind lrpf_framer lrpf_framer_monitor i_lrpf_framer_monitor (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .periodic_wake_interrupt(periodic_wake_interrupt),
    .user_switch_interrupt(user_switch_interrupt),
    .serial_tx_out_a(serial_tx_out_a),
    .packet_busy(packet_busy)
);

// File: sim/lrpf_pc_terminal.sv
`timescale 1ns/1ps
module lrpf_pc_terminal #(
    parameter int BIT_CYCLES = 217
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic serial_line,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic frame_err
);
    logic [7:0] shift_r;

    // eight data bits, no parity, one stop, sampled mid-bit
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
        frame_err = 1'b0;
        shift_r = 8'h00;
        forever begin
            @(negedge core_clk);
            if (!sys_rst && serial_line === 1'b0) begin
                repeat (BIT_CYCLES / 2) @(negedge core_clk);
                if (serial_line !== 1'b0) frame_err = 1'b1;
                for (int b = 0; b < 8; b++) begin
                    repeat (BIT_CYCLES) @(negedge core_clk);
                    shift_r[b] = serial_line;
                end
                repeat (BIT_CYCLES) @(negedge core_clk);
                if (serial_line !== 1'b1) frame_err = 1'b1;
                rx_byte <= shift_r;
                rx_valid <= 1'b1;
                @(negedge core_clk);
                rx_valid <= 1'b0;
            end
        end
    end
endmodule // lrpf_pc_terminal

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    // short sample period so the half-hour tick lands after two packets
    localparam logic [35:0] SAMP = 36'd56000;
    localparam logic [24:0] SECS = 25'd50;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic periodic_wake_interrupt = 1'b0;
    logic user_switch_interrupt = 1'b0;
    logic time_enable = 1'b0;
    logic [11:0] light_sample = 12'h000;
    logic [11:0] temp_sample = 12'h000;
    logic [15:0] threshold_level = 16'hffff;
    logic serial_tx_out_a;
    logic packet_busy;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic frame_err;
    logic [7:0] got[$];
    logic [31:0] lfsr_r = 32'd85650;
    int err_count = 0;
    int num_checks = 0;

    always #20 core_clk = ~core_clk;

    lrpf_framer #(.SAMPLE_CYCLES(SAMP), .SEC_CYCLES(SECS)) i_lrpf_framer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .periodic_wake_interrupt(periodic_wake_interrupt),
        .user_switch_interrupt(user_switch_interrupt),
        .time_enable(time_enable),
        .light_sample(light_sample),
        .temp_sample(temp_sample),
        .threshold_level(threshold_level),
        .serial_tx_out_a(serial_tx_out_a),
        .packet_busy(packet_busy)
    );

    lrpf_pc_terminal i_lrpf_pc_terminal (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .serial_line(serial_tx_out_a),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .frame_err(frame_err)
    );

    always @(posedge core_clk) begin
        if (rx_valid) got.push_back(rx_byte);
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // waits for a whole packet, then compares it byte by byte
    task pkt(input string s);
        int i;
        i = 0;
        while (got.size() < s.len() && i < 60000) begin
            @(posedge core_clk);
            i++;
        end
        for (i = 0; i < s.len(); i++) begin
            chk("packet byte", 8'(s[i]), (i < got.size()) ? got[i] : 8'hxx);
        end
        got = {};
    endtask

    task pulse(input logic p, input logic u);
        @(posedge core_clk);
        #1;
        periodic_wake_interrupt = p;
        user_switch_interrupt = u;
        repeat (4) @(posedge core_clk);
        #1;
        periodic_wake_interrupt = 1'b0;
        user_switch_interrupt = 1'b0;
    endtask

    task results;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (120000) @(posedge core_clk);
        err_count++;
        results();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        pulse(1'b0, 1'b1);
        // arrives while busy, so it must be dropped rather than queued
        pulse(1'b1, 1'b0);
        pkt("^2,0002,00$\n");
        repeat (300) @(posedge core_clk);
        pulse(1'b1, 1'b1);
        pkt("^1,0002,00$\n");
        // pkt returns on a rising edge, so step off it before driving inputs
        #1;
        lfsr_r = lfsr_next(lfsr_r);
        light_sample = lfsr_r[11:0];
        lfsr_r = lfsr_next(lfsr_r);
        temp_sample = lfsr_r[11:0];
        threshold_level = {4'h0, lfsr_r[11:0]};
        pkt($sformatf("^3,0009,%04d/%04d$\n", light_sample, temp_sample));
        repeat (3000) @(posedge core_clk);
        chk("extra bytes", 8'h00, 8'(got.size()));
        chk("frame error", 8'h00, {7'h00, frame_err});
        results();
    end
endmodule // testbench
